// ==== design/ir_adc_pkg.sv ====
// Constants, register map and types for the infrared ambient converter control.
// Assumes a 250 MHz APB clock and one aligned 32-bit word per register index.
package ir_adc_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_EMITTER_REC = 8'h1c;
    localparam logic [7:0] IDX_RECOVERY    = 8'h1d;
    localparam logic [7:0] IDX_GAIN        = 8'h1e;
    localparam logic [7:0] IDX_RANGE       = 8'h1f;
    localparam logic [7:0] IDX_CTRL        = 8'h20;
    localparam logic [7:0] IDX_STATUS      = 8'h21;

    // Reset values
    localparam logic [7:0] RST_EMITTER_REC = 8'h00;
    localparam logic [7:0] RST_RECOVERY    = 8'h70;
    localparam logic [7:0] RST_GAIN        = 8'h00;
    localparam logic [7:0] RST_RANGE       = 8'h00;

    // Field positions
    localparam int REC_CODE_MSB     = 6;
    localparam int REC_CODE_LSB     = 4;
    localparam int GAIN_MSB         = 2;
    localparam int RANGE_BIT        = 5;
    localparam int CTRL_START_BIT   = 0;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_RECOVER_BIT = 1;
    localparam int STAT_DONE_BIT    = 2;

    // Timing: one ADC clock at its base rate, rounded up to whole pclk cycles
    localparam int PCLK_PERIOD_NS = 4;
    localparam int ADC_CLK_NS     = 50;
    localparam int ADC_CLK_CYCLES = (ADC_CLK_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

    // Integration window in (gain-divided) ADC clocks
    localparam logic [8:0] INTEG_ADC_CLOCKS = 9'h0ff;
    localparam logic [8:0] REC_SHORTEST     = 9'h001;
    localparam int         REC_SHIFT_BASE   = 2;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b001,
        ST_RECOVER   = 3'b010,
        ST_INTEGRATE = 3'b100
    } conv_state_type;

    // Recovery length in ADC clocks: 1, 7, 15, ... 511
    function automatic logic [8:0] recovery_clocks(input logic [2:0] code);
        logic [9:0] full;
        // Four-bit shift amount, so codes 6 and 7 do not wrap to a short recovery
        full = 10'h001 << (4'(code) + 4'(REC_SHIFT_BASE));
        if (code == 3'd0) begin
            return REC_SHORTEST;
        end
        return 9'(full - 10'h001);
    endfunction

endpackage

// ==== design/adc_tick_gen.sv ====
// ADC clock enable generator: base ADC clock divided by two to the gain exponent.
// Assumes enable stays high for a whole conversion and gain is stable meanwhile.
`timescale 1ns/10ps
module adc_tick_gen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       enable,
    input  wire logic [2:0] gain,
    output logic            tick
);
    localparam logic [3:0] BASE_LAST = 4'(ir_adc_pkg::ADC_CLK_CYCLES - 1);

    logic [3:0] base_cnt_r;
    logic [6:0] div_cnt_r;
    logic [6:0] div_last;
    logic       tick_r;

    // Exponent 7 wraps the shift to zero, and the decrement then gives 127
    assign div_last = (7'h01 << gain) - 7'h01;
    assign tick     = tick_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt_r <= 4'h0;
            div_cnt_r  <= 7'h00;
            tick_r     <= 1'b0;
        end else if (!enable) begin
            base_cnt_r <= 4'h0;
            div_cnt_r  <= 7'h00;
            tick_r     <= 1'b0;
        end else if (base_cnt_r == BASE_LAST) begin
            base_cnt_r <= 4'h0;
            if (div_cnt_r == div_last) begin
                div_cnt_r <= 7'h00;
                tick_r    <= 1'b1;
            end else begin
                div_cnt_r <= div_cnt_r + 7'h01;
                tick_r    <= 1'b0;
            end
        end else begin
            base_cnt_r <= base_cnt_r + 4'h1;
            tick_r     <= 1'b0;
        end
    end
endmodule

// ==== design/adc_phase_timer.sv ====
// Down counter of ADC clock ticks for one conversion phase.
// Assumes load and tick never coincide; done is a one-cycle pulse.
`timescale 1ns/10ps
module adc_phase_timer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [8:0] load_value,
    input  wire logic       tick,
    output logic            done
);
    logic [8:0] cnt_r;
    logic       done_r;

    assign done = done_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 9'h000;
            done_r <= 1'b0;
        end else if (load) begin
            cnt_r  <= load_value;
            done_r <= 1'b0;
        end else if (tick && cnt_r != 9'h000) begin
            cnt_r  <= cnt_r - 9'h001;
            done_r <= (cnt_r == 9'h001);
        end else begin
            done_r <= 1'b0;
        end
    end
endmodule

// ==== design/ir_ambient_adc_config.sv ====
// Infrared ambient converter control: parameter registers on APB and the
// recovery / integration sequencer. Assumes an APB master, synchronous inputs
// and an analogue converter that follows the phase and range outputs.
`timescale 1ns/10ps

module ir_ambient_adc_config (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             adc_recovering,
    output logic             adc_integrating,
    output logic             adc_high_range,
    output logic [2:0]       adc_gain_exponent,
    output logic             conv_done
);
    logic [7:0]                 emitter_rec_r;
    logic [7:0]                 recovery_r;
    logic [7:0]                 gain_r;
    logic [7:0]                 range_r;
    logic                       done_flag_r;
    logic [31:0]                prdata_r;
    logic                       pready_r;
    logic                       pslverr_r;
    logic                       recovering_r;
    logic                       integrating_r;
    logic                       conv_range_r;
    logic [2:0]                 conv_gain_r;
    logic                       conv_done_r;
    ir_adc_pkg::conv_state_type state_r;

    logic       setup;
    logic       wr_en;
    logic [7:0] idx;
    logic       mapped;
    logic [7:0] rd_byte;
    logic       start_req;
    logic       tick_en;
    logic       tick;
    logic       timer_done;
    logic       timer_load;
    logic [8:0] timer_value;
    logic [2:0] rec_code;

    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign adc_recovering    = recovering_r;
    assign adc_integrating   = integrating_r;
    assign adc_high_range    = conv_range_r;
    assign adc_gain_exponent = conv_gain_r;
    assign conv_done         = conv_done_r;

    // Address decode: word-aligned index, upper bits must be zero
    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pready_r && pwrite;
    assign idx    = paddr[9:2];
    assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                    ((idx >= ir_adc_pkg::IDX_EMITTER_REC) && (idx <= ir_adc_pkg::IDX_STATUS));
    assign rec_code = recovery_r[ir_adc_pkg::REC_CODE_MSB:ir_adc_pkg::REC_CODE_LSB];

    // Start ignored unless idle, so parameters cannot shift mid-conversion
    assign start_req = wr_en && (idx == ir_adc_pkg::IDX_CTRL) && mapped &&
                       pwdata[ir_adc_pkg::CTRL_START_BIT] && (state_r == ir_adc_pkg::ST_IDLE);
    assign tick_en   = (state_r != ir_adc_pkg::ST_IDLE);

    // Read mux; status is sampled in the setup cycle
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            ir_adc_pkg::IDX_EMITTER_REC: rd_byte = emitter_rec_r;
            ir_adc_pkg::IDX_RECOVERY:    rd_byte = recovery_r;
            ir_adc_pkg::IDX_GAIN:        rd_byte = gain_r;
            ir_adc_pkg::IDX_RANGE:       rd_byte = range_r;
            ir_adc_pkg::IDX_STATUS: begin
                rd_byte[ir_adc_pkg::STAT_BUSY_BIT]    = tick_en;
                rd_byte[ir_adc_pkg::STAT_RECOVER_BIT] = recovering_r;
                rd_byte[ir_adc_pkg::STAT_DONE_BIT]    = done_flag_r;
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // APB answer: one wait-free access phase, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                prdata_r  <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
                pslverr_r <= !mapped;
            end else if (pready_r) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emitter_rec_r <= ir_adc_pkg::RST_EMITTER_REC;
            recovery_r    <= ir_adc_pkg::RST_RECOVERY;
            gain_r        <= ir_adc_pkg::RST_GAIN;
            range_r       <= ir_adc_pkg::RST_RANGE;
        end else if (wr_en && mapped) begin
            // Full bytes are kept, so host read-modify-write sees its own bits back
            unique case (idx)
                ir_adc_pkg::IDX_EMITTER_REC: emitter_rec_r <= pwdata[7:0];
                ir_adc_pkg::IDX_RECOVERY:    recovery_r    <= pwdata[7:0];
                ir_adc_pkg::IDX_GAIN:        gain_r        <= pwdata[7:0];
                ir_adc_pkg::IDX_RANGE:       range_r       <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Sticky completion flag: a new completion beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_r <= 1'b0;
        end else if (conv_done_r) begin
            done_flag_r <= 1'b1;
        end else if (wr_en && mapped && (idx == ir_adc_pkg::IDX_STATUS) &&
                     pwdata[ir_adc_pkg::STAT_DONE_BIT]) begin
            done_flag_r <= 1'b0;
        end
    end

    // Timer loads: recovery length at start, integration length after it
    assign timer_load  = start_req || ((state_r == ir_adc_pkg::ST_RECOVER) && timer_done);
    assign timer_value = start_req ? ir_adc_pkg::recovery_clocks(rec_code) : ir_adc_pkg::INTEG_ADC_CLOCKS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r       <= ir_adc_pkg::ST_IDLE;
            recovering_r  <= 1'b0;
            integrating_r <= 1'b0;
            conv_done_r   <= 1'b0;
        end else begin
            conv_done_r <= 1'b0;
            unique case (state_r)
                ir_adc_pkg::ST_IDLE: begin
                    if (start_req) begin
                        state_r      <= ir_adc_pkg::ST_RECOVER;
                        recovering_r <= 1'b1;
                    end
                end
                ir_adc_pkg::ST_RECOVER: begin
                    if (timer_done) begin
                        state_r       <= ir_adc_pkg::ST_INTEGRATE;
                        recovering_r  <= 1'b0;
                        integrating_r <= 1'b1;
                    end
                end
                ir_adc_pkg::ST_INTEGRATE: begin
                    if (timer_done) begin
                        state_r       <= ir_adc_pkg::ST_IDLE;
                        integrating_r <= 1'b0;
                        conv_done_r   <= 1'b1;
                    end
                end
                default: begin
                    state_r       <= ir_adc_pkg::ST_IDLE;
                    recovering_r  <= 1'b0;
                    integrating_r <= 1'b0;
                end
            endcase
        end
    end

    // range and gain latched at start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_range_r <= 1'b0;
            conv_gain_r  <= 3'h0;
        end else if (start_req) begin
            conv_range_r <= range_r[ir_adc_pkg::RANGE_BIT];
            conv_gain_r  <= gain_r[ir_adc_pkg::GAIN_MSB:0];
        end
    end

    adc_tick_gen u_tick_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (tick_en),
        .gain    (conv_gain_r),
        .tick    (tick)
    );

    adc_phase_timer u_phase_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (timer_load),
        .load_value (timer_value),
        .tick       (tick),
        .done       (timer_done)
    );

    // Helper counters watched only by the checks below
    logic [10:0] gap_cnt_r;
    logic [8:0]  rec_ticks_r;
    logic [10:0] gap_expect;
    logic [2:0]  rec_code_seen_r; // Copy at start, so a host rewrite mid-run cannot trip the check
    assign gap_expect = 11'(ir_adc_pkg::ADC_CLK_CYCLES) << conv_gain_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_r       <= 11'h000;
            rec_ticks_r     <= 9'h000;
            rec_code_seen_r <= 3'h0;
        end else begin
            // Idle preload of minus one: the first period already starts in the enable cycle
            if (!tick_en) begin
                gap_cnt_r <= 11'h7ff;
            end else begin
                gap_cnt_r <= tick ? 11'h000 : gap_cnt_r + 11'h001;
            end
            if (start_req) begin
                rec_ticks_r     <= 9'h000;
                rec_code_seen_r <= rec_code;
            end else if (recovering_r && tick) begin
                rec_ticks_r <= rec_ticks_r + 9'h001;
            end
        end
    end

    AST_TICK_SPACING: assert property (
        @(posedge pclk) disable iff (!presetn)
        tick |-> (gap_cnt_r + 11'h001 == gap_expect))
        else $error("ADC tick spacing does not match gain exponent");

    AST_RECOVERY_LENGTH: assert property (
        @(posedge pclk) disable iff (!presetn)
        (recovering_r && timer_done) |->
            (rec_ticks_r == ir_adc_pkg::recovery_clocks(rec_code_seen_r)))
        else $error("Recovery lasted the wrong number of ADC clocks");

    AST_START_RECOVERS: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_req |=> (recovering_r && !integrating_r) ##1 recovering_r)
        else $error("Conversion start did not enter recovery");

    AST_RANGE_FOLLOWS: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_req |=> (adc_high_range == $past(range_r[ir_adc_pkg::RANGE_BIT])))
        else $error("Range output does not follow range bit");

    AST_GAIN_STABLE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tick_en && !start_req) |=> $stable(conv_gain_r))
        else $error("Gain exponent changed during a conversion");

    AST_RESET_VALUES: assert property (
        @(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> (recovery_r == ir_adc_pkg::RST_RECOVERY && gain_r == ir_adc_pkg::RST_GAIN &&
                             range_r == ir_adc_pkg::RST_RANGE && !adc_high_range))
        else $error("Parameter registers left reset with wrong values");

    // Phase sequencing and latch checks
    AST_PHASES_EXCLUSIVE: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(adc_recovering && adc_integrating))
        else $error("Recovery and integration overlap");

    AST_RECOVER_TO_INTEGRATE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (adc_recovering && timer_done) |=> (!adc_recovering && adc_integrating))
        else $error("Integration did not follow the end of recovery");

    AST_LOAD_NO_TICK: assert property (
        @(posedge pclk) disable iff (!presetn)
        timer_load |-> !tick)
        else $error("Phase timer load met an ADC tick");

    AST_DONE_PULSE: assert property (
        @(posedge pclk) disable iff (!presetn)
        conv_done |-> (!adc_integrating ##1 !conv_done))
        else $error("Completion pulse longer than one cycle");

    AST_GAIN_LATCH: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_req |=> (adc_gain_exponent == $past(gain_r[ir_adc_pkg::GAIN_MSB:0])))
        else $error("Gain output does not follow gain parameter at start");

    AST_RANGE_HELD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tick_en && !start_req) |=> $stable(adc_high_range))
        else $error("Range output changed during a conversion");

    AST_RANGE_STORE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && mapped && (idx == ir_adc_pkg::IDX_RANGE)) |=> (range_r == $past(pwdata[7:0])))
        else $error("Range parameter did not keep the written byte");

    AST_RESET_PHASES: assert property (
        @(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> (!adc_recovering && !adc_integrating && !conv_done && adc_gain_exponent == 3'h0))
        else $error("Phase outputs not idle after reset");

endmodule

// ==== testbench/ir_host_model.sv ====
// Host model: APB master that programs the converter parameters.
// Assumes the slave raises pready within a few cycles of each access phase.
`timescale 1ns/10ps
module ir_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic hung;

    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        hung = 1'b0;
    end

    // One transfer; request held until pready is seen high at an edge, or for at most 16 edges
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) hung = 1'b1;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_range(input logic hi);
        logic [31:0] v;
        logic [31:0] dummy;
        logic        e;
        xfer(1'b0, 12'h07c, 32'h0000_0000, v, e);
        v[5] = hi;
        xfer(1'b1, 12'h07c, v, dummy, e);
    endtask
endmodule

// ==== testbench/ir_ambient_adc_config_tb_top.sv ====
// Testbench for the converter control: register map, refusals, phase timing.
// Assumes the host model above and the design's package constants.
`timescale 1ns/10ps
module ir_ambient_adc_config_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        adc_recovering;
    logic        adc_integrating;
    logic        adc_high_range;
    logic [2:0]  adc_gain_exponent;
    logic        conv_done;
    logic [31:0] rd;
    logic        er;
    logic [2:0]  g;
    logic [2:0]  seen_g;
    logic        seen_r;
    int          bad_count;
    int          cmp_count;
    int          rec_cnt;
    int          int_cnt;
    int          b_r;
    int          b_i;
    int          per;
    int          n;

    // Free-running 250 MHz clock
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    ir_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    ir_ambient_adc_config uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_recovering(adc_recovering), .adc_integrating(adc_integrating),
        .adc_high_range(adc_high_range), .adc_gain_exponent(adc_gain_exponent), .conv_done(conv_done));

    // Phase length counters; snapshots avoid racing a clear
    always @(posedge pclk) begin
        if (adc_recovering === 1'b1) rec_cnt <= rec_cnt + 1;
        if (adc_integrating === 1'b1) begin
            int_cnt <= int_cnt + 1;
            seen_g  <= adc_gain_exponent;
            seen_r  <= adc_high_range;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask

    // Small slack for the pipeline stages around each phase
    task automatic near(input string nm, input int e, input int v);
        cmp_count++;
        if (v < e - 2 || v > e + 3) begin
            bad_count++;
            $display("Error %s expected %0d seen %0d", nm, e, v);
        end
    endtask

    task automatic wrap_up;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        rec_cnt = 0;
        int_cnt = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            host.xfer(1'b0, 12'(12'h070 + 4 * k), 32'h0000_0000, rd, er);
            chk("reset value", (k == 1) ? 32'h0000_0070 : 32'h0000_0000, rd);
        end
        host.xfer(1'b1, 12'h07c, 32'h0000_0015, rd, er);
        host.set_range(1'b1);
        host.xfer(1'b0, 12'h07c, 32'h0000_0000, rd, er);
        chk("range readback", 32'h0000_0035, rd);
        host.xfer(1'b0, 12'h088, 32'h0000_0000, rd, er);
        chk("unmapped read err", 32'h0000_0001, {31'h0, er});
        chk("unmapped read data", 32'h0000_0000, rd);
        host.xfer(1'b1, 12'h06c, 32'h0000_00ff, rd, er);
        chk("unmapped write err", 32'h0000_0001, {31'h0, er});
        // Last case uses code 7 at gain 0, the recommended inverse
        for (int i = 0; i < 8; i++) begin
            g = (i < 4) ? 3'(3 - i) : 3'd0;
            host.xfer(1'b1, 12'h078, {29'h0, g}, rd, er);
            host.xfer(1'b1, 12'h074, {25'h0, 3'(i), 4'h0}, rd, er);
            host.set_range(i[0]);
            b_r = rec_cnt;
            b_i = int_cnt;
            host.xfer(1'b1, 12'h080, 32'h0000_0001, rd, er);
            host.xfer(1'b1, 12'h080, 32'h0000_0001, rd, er);
            host.xfer(1'b0, 12'h084, 32'h0000_0000, rd, er);
            chk("status busy", 32'h0000_0003, rd);
            n = 0;
            while (conv_done !== 1'b1 && n < 60000) begin
                @(posedge pclk);
                #1;
                n++;
            end
            if (n >= 60000) begin
                bad_count++;
                wrap_up();
            end
            per = ir_adc_pkg::ADC_CLK_CYCLES << g;
            near("recovery length", ((i == 0) ? 1 : (1 << (i + 2)) - 1) * per, rec_cnt - b_r);
            near("integration length", 255 * per, int_cnt - b_i);
            chk("gain output", {29'h0, g}, {29'h0, seen_g});
            chk("range output", {31'h0, i[0]}, {31'h0, seen_r});
            host.xfer(1'b0, 12'h084, 32'h0000_0000, rd, er);
            chk("done flag", 32'h0000_0001, {31'h0, rd[2]});
            host.xfer(1'b1, 12'h084, 32'h0000_0004, rd, er);
        end
        chk("host hang", 32'h0000_0000, {31'h0, host.hung});
        wrap_up();
    end
endmodule
